// File: verilog/dtc_top.sv
// Digital core of a tone transceiver: guard-timed receiver and burst-timed generator.
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/10ps
`include "dtc_params.svh"
module dtc_top #(
  parameter int BURST_REF_CYCLES = int'(`DTC_BURST_CNT)
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register bus.
  input wire dtc_pkg::dtc_axi_req_s axiReq,
  output dtc_pkg::dtc_axi_rsp_s axiRsp,
  // Receiver front end.
  input wire logic pairDetected,
  input wire logic [3:0] pairCode,
  input wire logic cpInBand,
  input wire logic cpLimited,
  // Receiver outputs.
  output logic earlySteerOut,
  output logic steerInGuardOut,
  output logic [3:0] rxCodeBits,
  // Shared open-drain interrupt or call-progress pin.
  output logic irqOrProgressOut,
  output logic irqOrProgressOe,
  // Tone output.
  output logic signed [8:0] toneSample,
  output logic toneDriveEn
);
  import dtc_pkg::*;

  localparam logic [`DTC_BURST_W-1:0] BURST_LEN = `DTC_BURST_W'(BURST_REF_CYCLES);

  logic [`DTC_CTRL_W-1:0] ctrl_q;
  dtc_guard_t gtp_q;
  dtc_guard_t gta_q;
  logic [`DTC_ACC_W-1:0] refAcc_q;
  logic refTick_q;
  logic awHeld_q, wHeld_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q, rdata_q;
  logic [3:0] wStrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic earlySteer_q, delayedSteer_q, steerGuard_q;
  dtc_guard_t guardCnt_q;
  logic [3:0] candCode_q, rxData_q;
  logic rxFull_q, irqPend_q, irqOe_q, txReady_q;
  logic [3:0] txCode_q;
  logic [7:0] twoOfEight_q;
  dtc_burst_e burst_q;
  logic [`DTC_BURST_W-1:0] burstCnt_q;
  logic signed [8:0] toneSample_q;
  logic toneDrive_q;

  logic toneEn, cpMode, irqEn, rxEnable, burstEn, singleTone, singleCol;
  logic doWrite, wrAddrOk, statusRead, txWrite, registerNow, burstDone;
  logic [31:0] wMask, rdMux;
  logic rdAddrOk;
  logic [`DTC_BURST_W-1:0] burstLen;
  logic toneOn, rowRun, colRun;
  logic [7:0] rowLen, colLen;
  logic signed [7:0] rowSample, colSample;
  dtc_guard_t guardLimit;

  assign toneEn = ctrl_q[`DTC_CTRL_TONE_EN];
  assign cpMode = ctrl_q[`DTC_CTRL_CP_MODE];
  assign irqEn = ctrl_q[`DTC_CTRL_IRQ_EN];
  assign burstEn = ctrl_q[`DTC_CTRL_BURST_EN];
  assign singleTone = ctrl_q[`DTC_CTRL_SINGLE];
  assign singleCol = ctrl_q[`DTC_CTRL_SINGLE_COL];
  assign rxEnable = ctrl_q[`DTC_CTRL_RX_EN] & ~cpMode;

  // Digit code to one-hot {column, row}; the table matches the receiver's encoding.
  function automatic logic [7:0] encode2of8(input logic [3:0] code);
    logic [7:0] r;
    r = 8'h00;
    unique case (code)
      4'h1: r = 8'h11;
      4'h2: r = 8'h21;
      4'h3: r = 8'h41;
      4'h4: r = 8'h12;
      4'h5: r = 8'h22;
      4'h6: r = 8'h42;
      4'h7: r = 8'h14;
      4'h8: r = 8'h24;
      4'h9: r = 8'h44;
      4'hA: r = 8'h28;
      4'hB: r = 8'h18;
      4'hC: r = 8'h48;
      4'hD: r = 8'h81;
      4'hE: r = 8'h82;
      4'hF: r = 8'h84;
      4'h0: r = 8'h88;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Reference tick: an exact fractional divider so every tone tracks the reference.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      refAcc_q <= '0;
      refTick_q <= 1'b0;
    end else if (refAcc_q + `DTC_ACC_W'(`DTC_REF_HZ) >= `DTC_ACC_W'(`DTC_SYS_HZ)) begin
      refAcc_q <= refAcc_q + `DTC_ACC_W'(`DTC_REF_HZ) - `DTC_ACC_W'(`DTC_SYS_HZ);
      refTick_q <= 1'b1;
    end else begin
      refAcc_q <= refAcc_q + `DTC_ACC_W'(`DTC_REF_HZ);
      refTick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave; address and data may arrive in either order.
  assign doWrite = awHeld_q & wHeld_q & ~bvalid_q;
  assign wMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
  assign wrAddrOk = (awAddr_q == `DTC_OFS_CTRL) || (awAddr_q == `DTC_OFS_TXDATA) ||
                    (awAddr_q == `DTC_OFS_GTP) || (awAddr_q == `DTC_OFS_GTA);
  assign txWrite = doWrite && (awAddr_q == `DTC_OFS_TXDATA) && wStrb_q[0];
  assign statusRead = arready_q & axiReq.arvalid &
                      ({axiReq.araddr[7:2], 2'b00} == `DTC_OFS_STATUS);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `DTC_RESP_OKAY;
      awAddr_q <= 8'h00;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
    end else begin
      if (awready_q && axiReq.awvalid) begin
        awHeld_q <= 1'b1;
        awready_q <= 1'b0;
        awAddr_q <= {axiReq.awaddr[7:2], 2'b00};
      end
      if (wready_q && axiReq.wvalid) begin
        wHeld_q <= 1'b1;
        wready_q <= 1'b0;
        wData_q <= axiReq.wdata;
        wStrb_q <= axiReq.wstrb;
      end
      if (doWrite) begin
        bvalid_q <= 1'b1;
        bresp_q <= wrAddrOk ? `DTC_RESP_OKAY : `DTC_RESP_SLVERR;
      end
      if (bvalid_q && axiReq.bready) begin
        bvalid_q <= 1'b0;
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_comb begin
    rdMux = 32'h00000000;
    rdAddrOk = 1'b1;
    unique case ({axiReq.araddr[7:2], 2'b00})
      `DTC_OFS_CTRL: rdMux = 32'(ctrl_q);
      `DTC_OFS_TXDATA: rdMux = 32'(txCode_q);
      `DTC_OFS_RXDATA: rdMux = 32'(rxData_q);
      `DTC_OFS_STATUS: begin
        rdMux[`DTC_ST_IRQ] = irqPend_q;
        rdMux[`DTC_ST_TX_READY] = txReady_q;
        rdMux[`DTC_ST_RX_FULL] = rxFull_q;
        rdMux[`DTC_ST_DSTEER] = delayedSteer_q;
      end
      `DTC_OFS_GTP: rdMux = 32'(gtp_q);
      `DTC_OFS_GTA: rdMux = 32'(gta_q);
      default: rdAddrOk = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `DTC_RESP_OKAY;
    end else if (arready_q && axiReq.arvalid) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rdMux;
      rresp_q <= rdAddrOk ? `DTC_RESP_OKAY : `DTC_RESP_SLVERR;
    end else if (rvalid_q && axiReq.rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign axiRsp = '{awready: awready_q, wready: wready_q, bvalid: bvalid_q, bresp: bresp_q,
                    arready: arready_q, rvalid: rvalid_q, rdata: rdata_q, rresp: rresp_q};

  // Configuration registers honour byte strobes.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `DTC_CTRL_RST;
      gtp_q <= `DTC_GTP_RST;
      gta_q <= `DTC_GTA_RST;
    end else if (doWrite) begin
      if (awAddr_q == `DTC_OFS_CTRL) begin
        ctrl_q <= `DTC_CTRL_W'((32'(ctrl_q) & ~wMask) | (wData_q & wMask));
      end
      if (awAddr_q == `DTC_OFS_GTP) begin
        gtp_q <= `DTC_GUARD_W'((32'(gtp_q) & ~wMask) | (wData_q & wMask));
      end
      if (awAddr_q == `DTC_OFS_GTA) begin
        gta_q <= `DTC_GUARD_W'((32'(gta_q) & ~wMask) | (wData_q & wMask));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receiver steering: a counter replaces the external RC guard network.
  assign guardLimit = delayedSteer_q ? gta_q : gtp_q;
  assign registerNow = refTick_q && (earlySteer_q != delayedSteer_q) && !delayedSteer_q &&
                       (guardCnt_q + 20'h00001 >= guardLimit);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      earlySteer_q <= 1'b0;
      delayedSteer_q <= 1'b0;
      steerGuard_q <= 1'b0;
      guardCnt_q <= '0;
      candCode_q <= 4'h0;
    end else begin
      earlySteer_q <= rxEnable & pairDetected;
      steerGuard_q <= delayedSteer_q & earlySteer_q;
      if (rxEnable && pairDetected) begin
        candCode_q <= pairCode;
      end
      // A mismatch shorter than the guard time resets the count and is forgotten.
      if (earlySteer_q == delayedSteer_q) begin
        guardCnt_q <= '0;
      end else if (refTick_q) begin
        if (guardCnt_q + 20'h00001 >= guardLimit) begin
          delayedSteer_q <= earlySteer_q;
          guardCnt_q <= '0;
        end else begin
          guardCnt_q <= guardCnt_q + 20'h00001;
        end
      end
    end
  end

  // The data latch moves only on a validated rising steering edge.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxData_q <= 4'h0;
    end else if (registerNow) begin
      rxData_q <= candCode_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxFull_q <= 1'b0;
    end else if (registerNow) begin
      rxFull_q <= 1'b1;
    end else if (statusRead) begin
      rxFull_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared pin: interrupt in tone mode, limited call-progress signal otherwise.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqPend_q <= 1'b0;
    end else if (irqEn && ((registerNow && !cpMode) || burstDone)) begin
      irqPend_q <= 1'b1;
    end else if (statusRead) begin
      irqPend_q <= 1'b0;
    end
  end

  // Open drain: enabling the driver pulls the pin low, release lets it float high.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqOe_q <= 1'b0;
    end else if (irqEn && cpMode) begin
      irqOe_q <= ~(cpInBand & cpLimited);
    end else if (irqEn) begin
      irqOe_q <= irqPend_q;
    end else begin
      irqOe_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit code register; disabling the tone output clears it.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txCode_q <= 4'h0;
      twoOfEight_q <= 8'h00;
    end else if (!toneEn) begin
      txCode_q <= 4'h0;
      twoOfEight_q <= 8'h00;
    end else if (txWrite) begin
      txCode_q <= wData_q[3:0];
      twoOfEight_q <= encode2of8(wData_q[3:0]);
    end
  end

  // Burst timer; the pause is counted with the tone silent.
  assign burstLen = cpMode ? (BURST_LEN << 1) : BURST_LEN;
  assign burstDone = (burst_q == TX_PAUSE) && refTick_q && (burstCnt_q >= burstLen - 21'h1);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_q <= TX_IDLE;
      burstCnt_q <= '0;
    end else if (!toneEn || !burstEn) begin
      burst_q <= TX_IDLE;
      burstCnt_q <= '0;
    end else if (txWrite) begin
      burst_q <= TX_BURST;
      burstCnt_q <= '0;
    end else begin
      unique case (burst_q)
        TX_IDLE: burstCnt_q <= '0;
        TX_BURST, TX_PAUSE: begin
          if (refTick_q && (burstCnt_q >= burstLen - 21'h1)) begin
            burst_q <= (burst_q == TX_BURST) ? TX_PAUSE : TX_IDLE;
            burstCnt_q <= '0;
          end else if (refTick_q) begin
            burstCnt_q <= burstCnt_q + 21'h1;
          end
        end
        default: burst_q <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txReady_q <= 1'b1;
    end else if (burstDone) begin
      txReady_q <= 1'b1;
    end else if (txWrite && burstEn) begin
      txReady_q <= 1'b0;
    end
  end

  // Without burst mode the tone plays while output is enabled; the host times it.
  assign toneOn = toneEn && (twoOfEight_q != 8'h00) && (!burstEn || burst_q == TX_BURST);
  assign rowRun = toneOn && (!singleTone || !singleCol);
  assign colRun = toneOn && (!singleTone || singleCol);

  always_comb begin
    rowLen = `DTC_DIV_L1;
    colLen = `DTC_DIV_H1;
    unique case (1'b1)
      twoOfEight_q[1]: rowLen = `DTC_DIV_L2;
      twoOfEight_q[2]: rowLen = `DTC_DIV_L3;
      twoOfEight_q[3]: rowLen = `DTC_DIV_L4;
      default: rowLen = `DTC_DIV_L1;
    endcase
    unique case (1'b1)
      twoOfEight_q[5]: colLen = `DTC_DIV_H2;
      twoOfEight_q[6]: colLen = `DTC_DIV_H3;
      twoOfEight_q[7]: colLen = `DTC_DIV_H4;
      default: colLen = `DTC_DIV_H1;
    endcase
  end

  // Two identical generator paths feed one summing register.
  dtc_tone_gen rowGen (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .refTick(refTick_q),
    .run(rowRun),
    .segLen(rowLen),
    .sample(rowSample)
  );

  dtc_tone_gen colGen (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .refTick(refTick_q),
    .run(colRun),
    .segLen(colLen),
    .sample(colSample)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      toneSample_q <= 9'sh000;
      toneDrive_q <= 1'b0;
    end else begin
      toneSample_q <= 9'(rowSample) + 9'(colSample);
      toneDrive_q <= toneEn;
    end
  end

  assign earlySteerOut = earlySteer_q;
  assign steerInGuardOut = steerGuard_q;
  assign rxCodeBits = rxData_q;
  assign irqOrProgressOut = 1'b0;
  assign irqOrProgressOe = irqOe_q;
  assign toneSample = toneSample_q;
  assign toneDriveEn = toneDrive_q;

endmodule

// File: verilog/dtc_params.svh
// Offsets, field positions, reset values and timing counts of the tone codec.
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// Register byte offsets on the AXI4-Lite port.
`define DTC_OFS_CTRL 8'h00
`define DTC_OFS_TXDATA 8'h04
`define DTC_OFS_RXDATA 8'h08
`define DTC_OFS_STATUS 8'h0C
`define DTC_OFS_GTP 8'h10
`define DTC_OFS_GTA 8'h14

// Control register fields.
`define DTC_CTRL_W 7
`define DTC_CTRL_RST 7'h00
`define DTC_CTRL_TONE_EN 0
`define DTC_CTRL_CP_MODE 1
`define DTC_CTRL_IRQ_EN 2
`define DTC_CTRL_RX_EN 3
`define DTC_CTRL_BURST_EN 4
`define DTC_CTRL_SINGLE 5
`define DTC_CTRL_SINGLE_COL 6

// Status register fields.
`define DTC_ST_IRQ 0
`define DTC_ST_TX_READY 1
`define DTC_ST_RX_FULL 2
`define DTC_ST_DSTEER 3

// AXI responses.
`define DTC_RESP_OKAY 2'h0
`define DTC_RESP_SLVERR 2'h2

// Clock rates and the reference tick generator.
`define DTC_SYS_HZ 200000000
`define DTC_REF_HZ 3579545
`define DTC_US_PER_S 1000000
`define DTC_ACC_W 28

// Guard times in microseconds and their reset counts in reference ticks.
`define DTC_GTP_US 20000
`define DTC_GTA_US 20000
`define DTC_GUARD_W 20
`define DTC_GTP_RST 20'((64'(`DTC_GTP_US) * 64'(`DTC_REF_HZ)) / 64'(`DTC_US_PER_S))
`define DTC_GTA_RST 20'((64'(`DTC_GTA_US) * 64'(`DTC_REF_HZ)) / 64'(`DTC_US_PER_S))

// Burst and pause length, doubled in call-progress mode.
`define DTC_BURST_US 51000
`define DTC_BURST_CNT ((64'(`DTC_BURST_US) * 64'(`DTC_REF_HZ)) / 64'(`DTC_US_PER_S))
`define DTC_BURST_W 21

// Segment lengths in reference ticks, 32 segments per tone period.
`define DTC_DIV_L1 8'd160
`define DTC_DIV_L2 8'd146
`define DTC_DIV_L3 8'd132
`define DTC_DIV_L4 8'd118
`define DTC_DIV_H1 8'd92
`define DTC_DIV_H2 8'd84
`define DTC_DIV_H3 8'd76
`define DTC_DIV_H4 8'd68

`endif

// File: verilog/dtc_pkg.sv
// Types shared by the tone codec modules.
package dtc_pkg;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } dtc_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dtc_axi_rsp_s;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_BURST = 3'b010,
    TX_PAUSE = 3'b100
  } dtc_burst_e;

  typedef logic [19:0] dtc_guard_t;

endpackage

// File: verilog/dtc_tone_gen.sv
// One tone path: segment divider, 32-step phase counter and sine lookup.
`timescale 1ns/10ps
`include "dtc_params.svh"
module dtc_tone_gen (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control.
  input wire logic refTick,
  input wire logic run,
  input wire logic [7:0] segLen,
  // Sample.
  output logic signed [7:0] sample
);
  import dtc_pkg::*;

  localparam logic [6:0] QSINE [0:8] = '{7'h00, 7'h19, 7'h31, 7'h47, 7'h5A, 7'h6A, 7'h75,
                                         7'h7D, 7'h7F};

  logic [7:0] segCnt_q;
  logic [4:0] phase_q;
  logic [3:0] quarterIdx;
  logic [6:0] mag;

  // The second quarter mirrors the first and the second half wave negates it, so only a quarter table is stored.
  always_comb begin
    quarterIdx = phase_q[3] ? 4'(5'h10 - {1'b0, phase_q[3:0]}) : phase_q[3:0];
    mag = QSINE[quarterIdx];
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      segCnt_q <= 8'h00;
      phase_q <= 5'h00;
    end else if (!run) begin
      segCnt_q <= 8'h00;
      phase_q <= 5'h00;
    end else if (refTick) begin
      if (segCnt_q >= segLen - 8'h01) begin
        segCnt_q <= 8'h00;
        phase_q <= phase_q + 5'h01;
      end else begin
        segCnt_q <= segCnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample <= 8'sh00;
    end else if (!run) begin
      sample <= 8'sh00;
    end else if (phase_q[4]) begin
      sample <= -$signed({1'b0, mag});
    end else begin
      sample <= $signed({1'b0, mag});
    end
  end

endmodule

// File: testbench/dtc_assertions.sv
// Port checker for the tone codec core.
`timescale 1ns/10ps
module dtc_checker (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Watched ports.
  input wire dtc_pkg::dtc_axi_req_s axiReq,
  input wire dtc_pkg::dtc_axi_rsp_s axiRsp,
  input wire logic pairDetected,
  input wire logic earlySteerOut,
  input wire logic steerInGuardOut,
  input wire logic [3:0] rxCodeBits,
  input wire logic irqOrProgressOut
);
  import dtc_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  a_early_follows: assert property (earlySteerOut |-> $past(pairDetected))
    else $error("early steer without a pair");
  a_guard_drops: assert property ($fell(earlySteerOut) |-> ##[0:1] !steerInGuardOut)
    else $error("guard output outlived early steer");
  a_latch_in_tone: assert property ($changed(rxCodeBits) |-> $past(earlySteerOut))
    else $error("receive code changed with no tone");
  a_pin_low: assert property (irqOrProgressOut == 1'b0)
    else $error("shared pin driven high");
  a_write_answer: assert property (
    axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready |-> ##[1:2] axiRsp.bvalid)
    else $error("write not answered");
  a_b_holds: assert property (axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp))
    else $error("write answer dropped");
  a_read_answer: assert property (axiReq.arvalid && axiRsp.arready |-> ##[1:2] axiRsp.rvalid)
    else $error("read not answered");
  a_r_holds: assert property (axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata))
    else $error("read answer dropped");
endmodule
bind dtc_top dtc_checker chk (.sys_clk(sys_clk), .rst_n(rst_n), .axiReq(axiReq),
  .axiRsp(axiRsp), .pairDetected(pairDetected), .earlySteerOut(earlySteerOut),
  .steerInGuardOut(steerInGuardOut), .rxCodeBits(rxCodeBits), .irqOrProgressOut(irqOrProgressOut));

// File: testbench/dtc_line_model.sv
// Far-end model: tone pair detector and call-progress comparator.
`timescale 1ns/10ps
module dtc_line_model (
  // Clock.
  input wire logic sys_clk,
  // Detector outputs.
  output logic pairDetected,
  output logic [3:0] pairCode,
  output logic cpInBand,
  output logic cpLimited
);
  logic [1:0] phase = 2'h0;
  initial begin
    pairDetected = 1'b0;
    pairCode = 4'h0;
    cpInBand = 1'b0;
    cpLimited = 1'b0;
  end
  // The comparator toggles in the reject band too; only the band flag tells them apart.
  always @(posedge sys_clk) begin
    phase <= phase + 2'h1;
    if (phase == 2'h3) begin
      cpLimited <= !cpLimited;
    end
  end
  task automatic toneOn(input logic [3:0] code);
    @(posedge sys_clk);
    pairDetected <= 1'b1;
    pairCode <= code;
  endtask
  // A released detector no longer holds its code, so it shows the inverse.
  task automatic toneOff();
    @(posedge sys_clk);
    pairDetected <= 1'b0;
    pairCode <= ~pairCode;
  endtask
  // The band flag moves just after an edge, like every other line output.
  task automatic setBand(input logic inBand);
    @(posedge sys_clk);
    cpInBand <= inBand;
  endtask
endmodule

// File: testbench/dtc_top_bench.sv
// Self-checking bench for the tone codec core.
`timescale 1ns/10ps
`include "dtc_params.svh"
module dtc_top_bench;
  import dtc_pkg::*;
  localparam int BURST = 20;
  logic sys_clk;
  logic rst_n;
  dtc_axi_req_s req;
  dtc_axi_rsp_s rsp;
  logic pairDetected;
  logic [3:0] pairCode;
  logic cpInBand;
  logic cpLimited;
  logic earlySteerOut;
  logic steerInGuardOut;
  logic [3:0] rxCodeBits;
  logic irqOrProgressOut;
  logic irqOrProgressOe;
  logic signed [8:0] toneSample;
  logic toneDriveEn;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  real tk = real'(`DTC_SYS_HZ) / real'(`DTC_REF_HZ);
  dtc_top #(.BURST_REF_CYCLES(BURST)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .axiReq(req),
    .axiRsp(rsp), .pairDetected(pairDetected), .pairCode(pairCode), .cpInBand(cpInBand),
    .cpLimited(cpLimited), .earlySteerOut(earlySteerOut), .steerInGuardOut(steerInGuardOut),
    .rxCodeBits(rxCodeBits), .irqOrProgressOut(irqOrProgressOut),
    .irqOrProgressOe(irqOrProgressOe), .toneSample(toneSample), .toneDriveEn(toneDriveEn));
  dtc_line_model line (.sys_clk(sys_clk), .pairDetected(pairDetected), .pairCode(pairCode),
    .cpInBand(cpInBand), .cpLimited(cpLimited));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Each access starts on a fresh edge so that no strobe is driven twice in one step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    @(posedge sys_clk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= s;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    rs = rsp.bresp;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge sys_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    rd = rsp.rdata;
    rs = rsp.rresp;
  endtask
  task automatic chkReg(input logic [7:0] a, input logic [31:0] exp);
    rdr(a);
    cmp("register", exp, rd);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic tRegs();
    chkReg(`DTC_OFS_CTRL, 32'h0);
    chkReg(`DTC_OFS_STATUS, 32'h2);
    chkReg(`DTC_OFS_GTP, 32'(`DTC_GTP_RST));
    rdr(8'h18);
    cmp("bad rresp", 32'h2, 32'(rs));
    wr(`DTC_OFS_STATUS, 32'h1);
    cmp("ro bresp", 32'h2, 32'(rs));
    wr(`DTC_OFS_GTP, 32'h3);
    // Only the low byte strobe is set, so the upper bytes keep their reset value.
    wr(`DTC_OFS_GTA, 32'h703, 4'h1);
    chkReg(`DTC_OFS_GTA, (32'(`DTC_GTA_RST) & 32'hFFFFFF00) | 32'h3);
    wr(`DTC_OFS_GTA, 32'h3);
    chkReg(`DTC_OFS_GTA, 32'h3);
    $display("regs done");
  endtask
  task automatic tRx();
    wr(`DTC_OFS_CTRL, 32'hC);
    line.toneOn(4'h5);
    cyc(600);
    cmp("early", 32'h1, 32'(earlySteerOut));
    cmp("guard", 32'h1, 32'(steerInGuardOut));
    cmp("pin", 32'h1, 32'(irqOrProgressOe));
    chkReg(`DTC_OFS_STATUS, 32'hF);
    chkReg(`DTC_OFS_STATUS, 32'hA);
    cmp("pin", 32'h0, 32'(irqOrProgressOe));
    chkReg(`DTC_OFS_RXDATA, 32'h5);
    line.toneOff();
    cyc(600);
    chkReg(`DTC_OFS_STATUS, 32'h2);
    chkReg(`DTC_OFS_RXDATA, 32'h5);
    line.toneOn(4'h9);
    cyc(100);
    cmp("early", 32'h1, 32'(earlySteerOut));
    line.toneOff();
    cyc(300);
    cmp("early", 32'h0, 32'(earlySteerOut));
    chkReg(`DTC_OFS_RXDATA, 32'h5);
    chkReg(`DTC_OFS_STATUS, 32'h2);
    $display("rx done");
  endtask
  task automatic tDrop();
    line.toneOn(4'h7);
    cyc(600);
    chkReg(`DTC_OFS_STATUS, 32'hF);
    chkReg(`DTC_OFS_RXDATA, 32'h7);
    line.toneOff();
    cyc(100);
    line.toneOn(4'h8);
    cyc(600);
    chkReg(`DTC_OFS_RXDATA, 32'h7);
    chkReg(`DTC_OFS_STATUS, 32'hA);
    line.toneOff();
    cyc(600);
    $display("dropout done");
  endtask
  task automatic tCp();
    logic p;
    wr(`DTC_OFS_CTRL, 32'hE);
    line.toneOn(4'h3);
    cyc(600);
    chkReg(`DTC_OFS_RXDATA, 32'h7);
    line.toneOff();
    line.setBand(1'b1);
    cyc(2);
    repeat (12) begin
      p = line.cpInBand & line.cpLimited;
      @(posedge sys_clk);
      cmp("cp pin", 32'(!p), 32'(irqOrProgressOe));
    end
    line.setBand(1'b0);
    cyc(3);
    cmp("cp pin", 32'h1, 32'(irqOrProgressOe));
    $display("cp done");
  endtask
  task automatic tBurst(input logic [31:0] ctrl, input int mult);
    int t0;
    int dt;
    wr(`DTC_OFS_CTRL, ctrl);
    wr(`DTC_OFS_TXDATA, 32'hB);
    t0 = cycles;
    rdr(`DTC_OFS_STATUS);
    cmp("tx busy", 32'h0, 32'(rd[1]));
    while (rd[1] !== 1'b1) rdr(`DTC_OFS_STATUS);
    dt = cycles - t0 - int'(2.0 * mult * BURST * tk);
    cmp("burst span", 32'h1, 32'(dt > -90 && dt < 90));
    if (!ctrl[1]) cmp("tx irq", 32'h1, 32'(rd[0]));
    $display("burst done");
  endtask
  task automatic tSeg(input logic [31:0] ctrl, input logic [3:0] code, input int ticks);
    logic signed [8:0] s;
    int t0;
    wr(`DTC_OFS_CTRL, ctrl);
    wr(`DTC_OFS_TXDATA, 32'(code));
    chkReg(`DTC_OFS_TXDATA, 32'(code));
    cmp("drive", 32'h1, 32'(toneDriveEn));
    // The first change may be the code switch itself, so time the third one.
    for (int i = 0; i < 3; i++) begin
      if (i == 2) t0 = cycles;
      s = toneSample;
      while (toneSample === s) @(posedge sys_clk);
    end
    t0 = cycles - t0 - int'(ticks * tk);
    cmp("segment", 32'h1, 32'(t0 > -70 && t0 < 70));
    $display("tone done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    req = '0;
    rst_n = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    tRegs();
    tRx();
    tDrop();
    tCp();
    tBurst(32'h15, 1);
    line.toneOn(4'h2);
    tBurst(32'h1F, 2);
    line.toneOff();
    chkReg(`DTC_OFS_RXDATA, 32'h7);
    tSeg(32'h21, 4'h1, 160);
    tSeg(32'h61, 4'h0, 68);
    wr(`DTC_OFS_CTRL, 32'h0);
    cyc(4);
    cmp("drive", 32'h0, 32'(toneDriveEn));
    cmp("tone", 32'h0, 32'(toneSample));
    chkReg(`DTC_OFS_TXDATA, 32'h0);
    summarize();
  end
endmodule
